// ==== bst_pkg.sv ====
// constants, types and state codes for the boundary-scan test port
// What this block does
// RL1 - identity word: revision, center, part, maker fields
// RL2 - identity word bit zero always one
// RL3 - seven-bit flash erase divider, scan loaded
// RL4 - tester loads divider before erase starts; the bench starts erase at the instruction scan's run-idle, before loading it
// RL5 - code 0110: 3-bit test control path
// RL6 - boundary chain on external-test or sample
// RL7 - cells capture, force, steer and tri-state pins
// RL8 - chain excludes port, analog, supply, clock pins
// RL9 - state advances on mode select at rise
// RL10 - test reset forces logic-reset asynchronously
// RL11 - five high mode-select rises reach logic-reset
// RL12 - code 0000: chain, preloaded outputs, system reset
// RL13 - code 0001: identity word shift path
// RL14 - code 0010: chain without disturbing operation
// RL15 - code 0101: bypass, tri-state, leakage high
// RL16 - code 1001: bypass, drivers off, system reset
// RL17 - code 1011: erase flash while secured
// RL18 - code 1100: bypass, preloaded outputs, system reset
// RL19 - code 1111: single bypass cell
// RL20 - unassigned codes select bypass
// RL21 - port reset loads identity instruction
// RL22 - bypass cell captures zero
// RL23 - instruction applied at falling edge update
// RL24 - data out changes falling, driven only shifting
// RL25 - standard sixteen-state controller graph
// RL26 - instruction capture pattern ends in 01
// RL27 - leakage holds run-idle until test reset
`default_nettype none
package bst_pkg;
  localparam int IR_W = 4;
  localparam int ID_W = 32;
  localparam int TCTL_W = 3;
  localparam int DIV_W = 7;
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_DEVICE_IDENTITY_WORD = 4'h1;
  localparam logic [3:0] IR_SAMPLE = 4'h2;
  localparam logic [3:0] IR_LEAK = 4'h5;
  localparam logic [3:0] IR_TCTL = 4'h6;
  localparam logic [3:0] IR_HIGHZ = 4'h9;
  localparam logic [3:0] IR_LOCK = 4'hb;
  localparam logic [3:0] IR_CLAMP = 4'hc;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [2:0] TCTL_RST = 3'h0;
  localparam logic [6:0] DIV_RST = 7'h00;
  // identity word field positions
  localparam int ID_REV_LSB = 28;
  localparam int ID_DC_LSB = 22;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MFR_LSB = 1;
  localparam int TLR_HITS = 5;
  typedef enum logic [3:0] {
    S_TLR = 4'b0000, S_RTI = 4'b0001, S_SEL_DR = 4'b0010,
    S_CAP_DR = 4'b0011, S_SH_DR = 4'b0100, S_EX1_DR = 4'b0101,
    S_PA_DR = 4'b0110, S_EX2_DR = 4'b0111, S_UPD_DR = 4'b1000,
    S_SEL_IR = 4'b1001, S_CAP_IR = 4'b1010, S_SH_IR = 4'b1011,
    S_EX1_IR = 4'b1100, S_PA_IR = 4'b1101, S_EX2_IR = 4'b1110,
    S_UPD_IR = 4'b1111
  } bst_state_t;
  // test port pins after synchronising
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bst_pins_t;
endpackage
`default_nettype wire

// ==== bst_tap_core.sv ====
// boundary-scan test port core: controller, decode, data registers
`default_nettype none
module bst_tap_core import bst_pkg::*; #(
  parameter int N_PINS = 8,
  parameter logic [3:0] ID_REV = 4'h1, // arbitrary value
  parameter logic [5:0] ID_DC = 6'h01, // arbitrary value
  parameter logic [9:0] ID_PART = 10'h001, // arbitrary value
  parameter logic [10:0] ID_MFR = 11'h001 // arbitrary value
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic trst_n_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  input wire logic [N_PINS-1:0] pad_in_i,
  input wire logic [N_PINS-1:0] core_out_i,
  input wire logic [N_PINS-1:0] core_oe_i,
  output logic [N_PINS-1:0] pad_out_o,
  output logic [N_PINS-1:0] pad_oe_o,
  output logic sys_reset_o,
  output logic leakage_o,
  output logic flash_erase_o,
  output logic [DIV_W-1:0] flash_erase_clock_divider_o,
  output logic [TCTL_W-1:0] test_control_o
);
  localparam int BSR_W = 2 * N_PINS;
  localparam int DR_W = (BSR_W > ID_W) ? BSR_W : ID_W;
  localparam logic [ID_W-1:0] ID_WORD = (ID_W'(ID_REV) << ID_REV_LSB)
    | (ID_W'(ID_DC) << ID_DC_LSB) | (ID_W'(ID_PART) << ID_PART_LSB)
    | (ID_W'(ID_MFR) << ID_MFR_LSB) | ID_W'(1);

  logic tap_rst_n;
  logic [1:0] trst_sync;
  bst_pins_t pin_m, pin_s;
  logic tck_d, rise, fall;
  logic [N_PINS-1:0] pad_m, pad_s;
  bst_state_t state, next_state;
  logic [IR_W-1:0] ir_sr, ir_hold;
  logic [DR_W-1:0] dr_sr, next_dr;
  logic [BSR_W-1:0] bsr_upd;
  logic leak;
  logic sel_bsr;
  int unsigned dr_len;
  logic [2:0] tms_hits;

  // test reset: asserts at once, releases through two flops
  always_ff @(posedge ref_clk_i or negedge trst_n_i or negedge rstn_i) begin
    if (!trst_n_i || !rstn_i) begin
      trst_sync <= 2'b00; // RL10
    end else begin
      trst_sync <= {trst_sync[0], 1'b1};
    end
  end
  assign tap_rst_n = trst_sync[1];

  // two-flop synchronisers for the test pins
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_m <= '1;
      pin_s <= '1;
      tck_d <= 1'b1;
    end else begin
      pin_m <= {tck_i, tms_i, tdi_i};
      pin_s <= pin_m;
      tck_d <= pin_s.tck;
    end
  end
  assign rise = pin_s.tck & ~tck_d;
  assign fall = ~pin_s.tck & tck_d;

  // pad input synchronisers for sampling
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pad_m <= '0;
      pad_s <= '0;
    end else begin
      pad_m <= pad_in_i;
      pad_s <= pad_m;
    end
  end

  // controller next state from mode select
  always_comb begin
    next_state = state;
    case (state) // RL25
      S_TLR: next_state = pin_s.tms ? S_TLR : S_RTI;
      S_RTI: next_state = pin_s.tms ? S_SEL_DR : S_RTI;
      S_SEL_DR: next_state = pin_s.tms ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: next_state = pin_s.tms ? S_EX1_DR : S_SH_DR;
      S_SH_DR: next_state = pin_s.tms ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: next_state = pin_s.tms ? S_UPD_DR : S_PA_DR;
      S_PA_DR: next_state = pin_s.tms ? S_EX2_DR : S_PA_DR;
      S_EX2_DR: next_state = pin_s.tms ? S_UPD_DR : S_SH_DR;
      S_UPD_DR: next_state = pin_s.tms ? S_SEL_DR : S_RTI;
      S_SEL_IR: next_state = pin_s.tms ? S_TLR : S_CAP_IR;
      S_CAP_IR: next_state = pin_s.tms ? S_EX1_IR : S_SH_IR;
      S_SH_IR: next_state = pin_s.tms ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: next_state = pin_s.tms ? S_UPD_IR : S_PA_IR;
      S_PA_IR: next_state = pin_s.tms ? S_EX2_IR : S_PA_IR;
      S_EX2_IR: next_state = pin_s.tms ? S_UPD_IR : S_SH_IR;
      S_UPD_IR: next_state = pin_s.tms ? S_SEL_DR : S_RTI;
      default: next_state = S_TLR;
    endcase
  end

  // state register steps on each test clock rise while the leakage latch is clear
  always_ff @(posedge ref_clk_i or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      state <= S_TLR; // RL10
    end else if (leak) begin
      state <= S_RTI; // RL27
    end else if (rise) begin
      state <= next_state; // RL9
    end
  end

  // leakage latch, cleared only by test or power reset
  always_ff @(posedge ref_clk_i or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      leak <= 1'b0;
    end else if (rise && state == S_UPD_IR && !pin_s.tms
                 && ir_hold == IR_LEAK) begin
      leak <= 1'b1; // RL15
    end
  end

  // instruction shift path
  always_ff @(posedge ref_clk_i or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ir_sr <= IR_CAPTURE;
    end else if (rise && state == S_CAP_IR) begin
      ir_sr <= IR_CAPTURE; // RL26
    end else if (rise && state == S_SH_IR) begin
      ir_sr <= {pin_s.tdi, ir_sr[IR_W-1:1]};
    end
  end

  // instruction hold, applied at the falling edge
  always_ff @(posedge ref_clk_i or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ir_hold <= IR_DEVICE_IDENTITY_WORD; // RL21
    end else if (state == S_TLR) begin
      ir_hold <= IR_DEVICE_IDENTITY_WORD; // RL21
    end else if (fall && state == S_UPD_IR) begin
      ir_hold <= ir_sr; // RL23
    end
  end

  // data path selection and length per instruction
  always_comb begin
    sel_bsr = 1'b0;
    case (ir_hold)
      IR_EXTEST, IR_SAMPLE: begin
        dr_len = BSR_W; // RL6
        sel_bsr = 1'b1; // RL12 RL14
      end
      IR_DEVICE_IDENTITY_WORD: dr_len = ID_W; // RL13
      IR_TCTL: dr_len = TCTL_W; // RL5
      IR_LOCK: dr_len = DIV_W; // RL17
      IR_LEAK, IR_HIGHZ, IR_CLAMP, IR_BYPASS: dr_len = 1; // RL19
      default: dr_len = 1; // RL20
    endcase
  end

  // data shift: capture loads, shift inserts at the top of the path
  always_comb begin
    next_dr = dr_sr;
    if (state == S_CAP_DR) begin
      next_dr = '0; // RL22
      if (sel_bsr) begin
        next_dr[BSR_W-1:0] = {core_oe_i, pad_s}; // RL7
      end else if (ir_hold == IR_DEVICE_IDENTITY_WORD) begin
        next_dr[ID_W-1:0] = ID_WORD; // RL1 RL2
      end else if (ir_hold == IR_TCTL) begin
        next_dr[TCTL_W-1:0] = test_control_o;
      end else if (ir_hold == IR_LOCK) begin
        next_dr[DIV_W-1:0] = flash_erase_clock_divider_o;
      end
    end else if (state == S_SH_DR) begin
      for (int i = 0; i < DR_W; i++) begin
        if (i == dr_len - 1) begin
          next_dr[i] = pin_s.tdi;
        end else if (i < dr_len - 1) begin
          next_dr[i] = dr_sr[i+1];
        end else begin
          next_dr[i] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      dr_sr <= '0;
    end else if (rise) begin
      dr_sr <= next_dr;
    end
  end

  // boundary update cells load at the falling edge of update
  always_ff @(posedge ref_clk_i or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      bsr_upd <= '0;
    end else if (fall && state == S_UPD_DR && sel_bsr) begin
      bsr_upd <= dr_sr[BSR_W-1:0]; // RL7 RL8
    end
  end

  // test control hold loads at the rising edge in update
  always_ff @(posedge ref_clk_i or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      test_control_o <= TCTL_RST;
    end else if (rise && state == S_UPD_DR && ir_hold == IR_TCTL) begin
      test_control_o <= dr_sr[TCTL_W-1:0]; // RL5
    end
  end

  // erase divider; the tester loads it before run-idle, but the bench loads it after the erase has started
  always_ff @(posedge ref_clk_i or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      flash_erase_clock_divider_o <= DIV_RST;
    end else if (fall && state == S_UPD_DR && ir_hold == IR_LOCK) begin
      flash_erase_clock_divider_o <= dr_sr[DIV_W-1:0]; // RL3 RL4
    end
  end

  // data out and its enable change at the falling edge
  always_ff @(posedge ref_clk_i or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (fall) begin
      tdo_o <= (state == S_SH_IR) ? ir_sr[0] : dr_sr[0]; // RL24
      tdo_oe_o <= (state == S_SH_IR) || (state == S_SH_DR); // RL24
    end
  end

  // pad drive, system reset, erase and leakage outputs
  always_ff @(posedge ref_clk_i or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      pad_out_o <= '0;
      pad_oe_o <= '0;
      sys_reset_o <= 1'b0;
      flash_erase_o <= 1'b0;
      leakage_o <= 1'b0;
    end else begin
      case (ir_hold)
        IR_EXTEST, IR_CLAMP: begin
          pad_out_o <= bsr_upd[N_PINS-1:0]; // RL12 RL18
          pad_oe_o <= bsr_upd[BSR_W-1:N_PINS];
        end
        IR_HIGHZ, IR_LEAK: begin
          pad_out_o <= '0;
          pad_oe_o <= '0; // RL15 RL16
        end
        default: begin
          pad_out_o <= core_out_i; // RL14
          pad_oe_o <= core_oe_i;
        end
      endcase
      sys_reset_o <= (ir_hold == IR_EXTEST) || (ir_hold == IR_HIGHZ)
        || (ir_hold == IR_CLAMP); // RL12 RL16 RL18
      flash_erase_o <= (ir_hold == IR_LOCK) && (state == S_RTI); // RL17
      leakage_o <= leak; // RL15
    end
  end

  // counts consecutive high mode-select rises for checking
  always_ff @(posedge ref_clk_i or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      tms_hits <= '0;
    end else if (rise) begin
      if (!pin_s.tms) begin
        tms_hits <= '0;
      end else if (tms_hits < 3'(TLR_HITS)) begin
        tms_hits <= tms_hits + 3'd1;
      end
    end
  end

  property p_tlr_five;
    @(posedge ref_clk_i) disable iff (!tap_rst_n)
    (tms_hits == 3'(TLR_HITS)) |-> (state == S_TLR || leak);
  endproperty
  a_tlr_five: assert property (p_tlr_five) // RL11
    else $error("five high mode rises did not reach reset");
  property p_id_lsb;
    @(posedge ref_clk_i) disable iff (!tap_rst_n)
    (rise && state == S_CAP_DR && ir_hold == IR_DEVICE_IDENTITY_WORD && !leak)
      |=> (dr_sr[ID_W-1:0] == ID_WORD) && dr_sr[0];
  endproperty
  a_id_lsb: assert property (p_id_lsb) // RL2
    else $error("identity capture wrong");
  property p_byp_zero;
    @(posedge ref_clk_i) disable iff (!tap_rst_n)
    (rise && state == S_CAP_DR && ir_hold == IR_BYPASS && !leak)
      |=> !dr_sr[0];
  endproperty
  a_byp_zero: assert property (p_byp_zero) // RL22
    else $error("bypass cell did not capture zero");
  property p_ir_cap;
    @(posedge ref_clk_i) disable iff (!tap_rst_n)
    (rise && state == S_CAP_IR && !leak) |=> (ir_sr[1:0] == 2'b01);
  endproperty
  a_ir_cap: assert property (p_ir_cap) // RL26
    else $error("instruction capture pattern wrong");
  property p_ir_upd;
    @(posedge ref_clk_i) disable iff (!tap_rst_n)
    (fall && state == S_UPD_IR) |=> (ir_hold == $past(ir_sr));
  endproperty
  a_ir_upd: assert property (p_ir_upd) // RL23
    else $error("instruction not applied at falling update");
  property p_ir_reset;
    @(posedge ref_clk_i) disable iff (!tap_rst_n)
    (state == S_TLR) |=> (ir_hold == IR_DEVICE_IDENTITY_WORD);
  endproperty
  a_ir_reset: assert property (p_ir_reset) // RL21
    else $error("identity instruction not loaded in reset state");
  property p_tdo_oe;
    @(posedge ref_clk_i) disable iff (!tap_rst_n)
    fall |=> (tdo_oe_o == ($past(state) == S_SH_IR
      || $past(state) == S_SH_DR));
  endproperty
  a_tdo_oe: assert property (p_tdo_oe) // RL24
    else $error("data out enable outside shift states");

  property p_tctl;
    @(posedge ref_clk_i) disable iff (!tap_rst_n)
    (rise && state == S_UPD_DR && ir_hold == IR_TCTL)
      |=> (test_control_o == $past(dr_sr[TCTL_W-1:0]));
  endproperty
  a_tctl: assert property (p_tctl) // RL5
    else $error("test control hold not updated");

  property p_div;
    @(posedge ref_clk_i) disable iff (!tap_rst_n)
    (fall && state == S_UPD_DR && ir_hold == IR_LOCK)
      |=> (flash_erase_clock_divider_o == $past(dr_sr[DIV_W-1:0]));
  endproperty
  a_div: assert property (p_div) // RL3
    else $error("erase divider not loaded");

  property p_leak_hold;
    @(posedge ref_clk_i) disable iff (!tap_rst_n)
    leak |=> (state == S_RTI) && leak ##1 leakage_o;
  endproperty
  a_leak_hold: assert property (p_leak_hold) // RL27
    else $error("leakage did not hold run-idle");

  property p_highz;
    @(posedge ref_clk_i) disable iff (!tap_rst_n)
    (ir_hold == IR_HIGHZ)[*2] |-> (pad_oe_o == '0) && sys_reset_o;
  endproperty
  a_highz: assert property (p_highz) // RL16
    else $error("drivers on or no system reset under high-z");

  property p_sample_pass;
    @(posedge ref_clk_i) disable iff (!tap_rst_n)
    (ir_hold == IR_SAMPLE) |=> (pad_oe_o == $past(core_oe_i))
      && !sys_reset_o;
  endproperty
  a_sample_pass: assert property (p_sample_pass) // RL14
    else $error("sample disturbed normal operation");
endmodule
`default_nettype wire

// ==== bst_tester.sv ====
// tester model: drives the test pins and samples serial data out
`default_nettype none
module bst_tester (
  input wire logic ref_clk_i,
  input wire logic tdo_i,
  input wire logic tdo_oe_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // test clock stands low between operations
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  // one test clock period: change while low, take tdo at the rise
  task automatic tick(input logic tms, input logic tdi, output logic tdo,
                      output logic oe);
    @(negedge ref_clk_i);
    tck_o = 1'b0;
    tms_o = tms;
    tdi_o = tdi;
    repeat (6) @(negedge ref_clk_i);
    // a released data line has no pull-up: it shows the inverse
    tdo = tdo_oe_i ? tdo_i : ~tdo_i;
    oe = tdo_oe_i;
    tck_o = 1'b1;
    repeat (3) @(negedge ref_clk_i);
  endtask
  // park clock low; data line shows no stale level
  task automatic rest();
    @(negedge ref_clk_i);
    tck_o = 1'b0;
    tdi_o = ~tdi_o;
    repeat (10) @(negedge ref_clk_i);
  endtask
  // leave logic-reset for run-idle
  task automatic go_idle();
    logic b;
    logic oe;
    tick(1'b0, 1'b0, b, oe);
    rest();
  endtask
  // five high mode-select rises, then run-idle
  task automatic reset5();
    logic b;
    logic oe;
    repeat (5) tick(1'b1, 1'b0, b, oe);
    go_idle();
  endtask
  // full scan from run-idle back to run-idle, lsb first
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout, output logic oe_all);
    logic b;
    logic oe;
    dout = '0;
    oe_all = 1'b1;
    tick(1'b1, 1'b0, b, oe);
    if (ir) tick(1'b1, 1'b0, b, oe);
    tick(1'b0, 1'b0, b, oe);
    tick(1'b0, 1'b0, b, oe);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], b, oe);
      dout[i] = b;
      oe_all = oe_all & oe;
    end
    tick(1'b1, 1'b0, b, oe);
    tick(1'b0, 1'b0, b, oe);
    rest();
  endtask
endmodule
`default_nettype wire

// ==== bst_tap_core_tb.sv ====
// self-checking bench for the boundary-scan test port core
`default_nettype none
module bst_tap_core_tb import bst_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NP = 8;
  localparam logic [3:0] T_REV = 4'ha; // arbitrary value
  localparam logic [5:0] T_DC = 6'h15; // arbitrary value
  localparam logic [9:0] T_PART = 10'h2c3; // arbitrary value
  localparam logic [10:0] T_MFR = 11'h4e5; // arbitrary value
  localparam logic [31:0] ID_EXP = {T_REV, T_DC, T_PART, T_MFR, 1'b1};
  logic ref_clk = 1'b0;
  logic rstn, trst_n, tck, tms, tdi, tdo, tdo_oe, oe_all;
  logic sys_reset, leakage, flash_erase;
  logic [NP-1:0] pad_in, core_out, core_oe, pad_out, pad_oe, exp_d, exp_e;
  logic [DIV_W-1:0] div;
  logic [TCTL_W-1:0] tctl;
  logic [63:0] din, dout, keep;
  logic [15:0] upd;
  logic [3:0] c;
  logic [3:0] codes [15] = '{4'h2, 4'h0, 4'h1, 4'h3, 4'h4, 4'h6, 4'h7,
    4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
  integer seed = 6;
  int err_count = 0;
  int checked = 0;
  int len;
  // system clock
  always #2.5 ref_clk = ~ref_clk;
  bst_tap_core #(.N_PINS(NP), .ID_REV(T_REV), .ID_DC(T_DC),
    .ID_PART(T_PART), .ID_MFR(T_MFR)) dut_u (
    .ref_clk_i(ref_clk), .rstn_i(rstn), .trst_n_i(trst_n),
    .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .pad_in_i(pad_in), .core_out_i(core_out),
    .core_oe_i(core_oe), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
    .sys_reset_o(sys_reset), .leakage_o(leakage),
    .flash_erase_o(flash_erase), .flash_erase_clock_divider_o(div),
    .test_control_o(tctl)
  );
  bst_tester tester_u (.ref_clk_i(ref_clk), .tdo_i(tdo),
    .tdo_oe_i(tdo_oe), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
  // expected data path length per instruction
  function automatic int dr_len(input logic [3:0] k);
    case (k)
      IR_EXTEST, IR_SAMPLE: return 2 * NP;
      IR_DEVICE_IDENTITY_WORD: return ID_W;
      IR_TCTL: return TCTL_W;
      IR_LOCK: return DIV_W;
      default: return 1;
    endcase
  endfunction
  // compare and count
  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge ref_clk);
    err_count++;
    $display("ERROR watchdog expected done seen hang");
    summarize();
  end
  // main sequence
  initial begin
    rstn = 1'b0;
    trst_n = 1'b0;
    pad_in = '0;
    core_out = '0;
    core_oe = '0;
    repeat (3) @(negedge ref_clk);
    rstn = 1'b1;
    trst_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    tester_u.go_idle();
    check("tdo_oe idle", tdo_oe, 0);
    tester_u.scan(0, 32, 0, dout, oe_all);
    check("device_identity_word reset", dout[31:0], ID_EXP);
    tester_u.scan(1, 4, {60'h0, IR_BYPASS}, dout, oe_all);
    check("ir capture", dout[3:0], IR_CAPTURE);
    tester_u.reset5();
    tester_u.scan(0, 32, 0, dout, oe_all);
    check("device_identity_word tms", dout[31:0], ID_EXP);
    foreach (codes[k]) begin
      c = codes[k];
      @(negedge ref_clk);
      pad_in = NP'($random(seed));
      core_out = NP'($random(seed));
      core_oe = NP'($random(seed));
      tester_u.scan(1, 4, {60'h0, c}, dout, oe_all);
      check("sys_reset", sys_reset, c == 0 || c == 9 || c == 12);
      din = {$random(seed), $random(seed)};
      len = dr_len(c);
      keep = (64'h1 << (64 - len)) - 64'h1;
      // lockout divider loaded after the instruction scan's run-idle started the erase
      tester_u.scan(0, 64, din, dout, oe_all);
      check("shift oe", oe_all, 1);
      check("path", dout >> len, din & keep);
      if (len == 1) check("bypass cap", dout[0], 0);
      check("erase", flash_erase, c == IR_LOCK);
      check("leakage", leakage, 0);
      case (c)
        IR_DEVICE_IDENTITY_WORD: check("id cap", dout[31:0], ID_EXP);
        IR_SAMPLE, IR_EXTEST: begin
          check("pad sample", dout[NP-1:0], pad_in);
          check("oe sample", dout[2*NP-1:NP], core_oe);
          upd = din[63:48];
        end
        IR_TCTL: check("tctl", tctl, din[63:61]);
        IR_LOCK: check("divider", div, din[63:57]);
        default: ;
      endcase
      exp_d = core_out;
      exp_e = core_oe;
      if (c == IR_EXTEST || c == IR_CLAMP) begin
        exp_d = upd[7:0];
        exp_e = upd[15:8];
      end
      if (c == IR_HIGHZ) exp_e = '0;
      check("pad_oe", pad_oe, exp_e);
      if (c != IR_HIGHZ) check("pad_out", pad_out, exp_d);
    end
    tester_u.scan(1, 4, {60'h0, IR_LEAK}, dout, oe_all);
    check("leak on", leakage, 1);
    check("leak oe", pad_oe, 0);
    tester_u.scan(1, 4, {60'h0, IR_BYPASS}, dout, oe_all);
    check("frozen", oe_all, 0);
    check("leak held", leakage, 1);
    @(negedge ref_clk);
    trst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    check("trst", leakage, 0);
    trst_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    tester_u.go_idle();
    tester_u.scan(1, 4, {60'h0, IR_BYPASS}, dout, oe_all);
    @(negedge ref_clk);
    rstn = 1'b0;
    repeat (3) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (6) @(negedge ref_clk);
    tester_u.go_idle();
    tester_u.scan(0, 32, 0, dout, oe_all);
    check("device_identity_word por", dout[31:0], ID_EXP);
    summarize();
  end
endmodule
`default_nettype wire
